// [rtl/adc_frontend_regs.vh]
/*
 * Register map, field positions, reset values and framing constants of the
 * Manchester sinc converter front end.
 * Assumes byte addresses on a 32-bit APB, one aligned word per register.
 */
`ifndef ADC_FRONTEND_REGS_VH
`define ADC_FRONTEND_REGS_VH

// register byte offsets
`define CTRL_OFFSET          12'h000
`define SYNC_STATUS_OFFSET   12'h004
`define CLOCK_COUNT_OFFSET   12'h008
`define HIGH_WORD_BASE       12'h010
`define LOW_BYTE_BASE        12'h030

// converter_control fields
`define CTRL_OSR_LSB         0
`define CTRL_OSR_MSB         1
`define CTRL_ENABLE_LSB      2
`define CTRL_ENABLE_MSB      4
`define CTRL_IRQEN_LSB       5
`define CTRL_IRQEN_MSB       7
`define CTRL_READY_LSB       8
`define CTRL_READY_MSB       10

// decoder_sync_status fields
`define STAT_LOCK_LSB        0
`define STAT_LOCK_MSB        2
`define STAT_MSEL_LSB        4
`define STAT_MSEL_MSB        5

// reset values
`define CTRL_OSR_RESET       2'h0
`define CTRL_ENABLE_RESET    3'h0
`define CTRL_IRQEN_RESET     3'h0
`define MSEL_RESET           2'h0
`define SAMPLE_RESET         24'h000000

// framing: slot 0 sync, slot 1 channel 0, slot 2 channel 1
`define FRAME_LAST_SLOT      2'h2
`define SYNC_PATTERN         8'hb4
`define HALF_EST_INIT        12'hfff

// measurement window: 512 reference periods, counted 0..511
`define MEAS_WINDOW_LAST     9'h1ff

`endif

// [rtl/manchester_decoder.v]
/*
 * One Manchester line decoder with sync detector.
 * Assumes the line is asynchronous to clk and that clk is many times
 * faster than the modulator's bit rate.
 */
`timescale 1ns/1ps
`default_nettype none
`include "adc_frontend_regs.vh"

module manchester_decoder (
    input  wire        clk,
    input  wire        rst,
    input  wire        enable,
    input  wire        lineIn,
    output reg         locked,
    output reg         frameStrobe,
    output reg         syncStrobe,
    output reg         ch0Bit,
    output reg         ch1Bit
);

    reg        lineSync1_q;
    reg        lineSync2_q;
    reg        linePrev_q;
    reg [11:0] edgeCnt_q;
    reg [11:0] sinceMid_q;
    reg [11:0] halfEst_q;
    reg [23:0] shift_q;
    reg [1:0]  slot_q;
    reg [2:0]  patIdx_q;
    reg        ch0Hold_q;

    wire        lineEdge  = lineSync2_q ^ linePrev_q;
    wire [12:0] threshold = {1'b0, halfEst_q} + {2'b00, halfEst_q[11:1]};
    wire        midEdge   = lineEdge && ({1'b0, sinceMid_q} > threshold);
    wire        bitVal    = lineSync2_q;
    wire [23:0] shiftNext = {shift_q[22:0], bitVal};
    wire [7:0]  syncBits  = {shiftNext[23], shiftNext[20], shiftNext[17], shiftNext[14],
                             shiftNext[11], shiftNext[8], shiftNext[5], shiftNext[2]};
    wire [7:0]  syncWord   = `SYNC_PATTERN;
    wire        expectSync = syncWord[patIdx_q];

    // two-stage synchroniser, the first stage feeds only the second
    always @(posedge clk) begin
        if (rst) begin
            lineSync1_q <= 1'b0;
            lineSync2_q <= 1'b0;
            linePrev_q  <= 1'b0;
        end else begin
            lineSync1_q <= lineIn;
            lineSync2_q <= lineSync1_q;
            linePrev_q  <= lineSync2_q;
        end
    end

    // clock recovery from the line itself: the shortest edge spacing is half a bit [R1] [R12]
    always @(posedge clk) begin
        if (rst || !enable) begin
            // start saturated: the gap from enable to the first edge must not train the estimate
            edgeCnt_q  <= 12'hfff;
            sinceMid_q <= 12'h000;
            halfEst_q  <= `HALF_EST_INIT;
        end else begin
            if (lineEdge) begin
                edgeCnt_q <= 12'h000;
                if (edgeCnt_q < halfEst_q && edgeCnt_q != 12'h000)
                    halfEst_q <= edgeCnt_q;
            end else if (edgeCnt_q != 12'hfff) begin
                edgeCnt_q <= edgeCnt_q + 12'h001;
            end
            if (midEdge)
                sinceMid_q <= 12'h000;
            else if (sinceMid_q != 12'hfff)
                sinceMid_q <= sinceMid_q + 12'h001;
        end
    end

    // hunt for the pattern, then follow the frame and drop lock on a bad sync bit [R2] [R3]
    always @(posedge clk) begin
        frameStrobe <= 1'b0;
        syncStrobe  <= 1'b0;
        if (rst || !enable) begin
            locked    <= 1'b0;
            shift_q   <= 24'h000000;
            slot_q    <= 2'h0;
            patIdx_q  <= 3'h7;
            ch0Hold_q <= 1'b0;
            ch0Bit    <= 1'b0;
            ch1Bit    <= 1'b0;
        end else if (midEdge) begin
            shift_q <= shiftNext;
            if (!locked) begin
                if (syncBits == `SYNC_PATTERN) begin
                    locked   <= 1'b1;
                    slot_q   <= 2'h0;
                    patIdx_q <= 3'h7;
                end
            end else begin
                case (slot_q)
                    2'h0: begin
                        if (bitVal != expectSync) begin
                            locked <= 1'b0;
                        end else begin
                            syncStrobe <= 1'b1;
                            patIdx_q   <= patIdx_q - 3'h1;
                            slot_q     <= 2'h1;
                        end
                    end
                    2'h1: begin
                        ch0Hold_q <= bitVal;
                        slot_q    <= `FRAME_LAST_SLOT;
                    end
                    2'h2: begin
                        ch0Bit      <= ch0Hold_q;
                        ch1Bit      <= bitVal;
                        frameStrobe <= 1'b1;
                        slot_q      <= 2'h0;
                    end
                    default: slot_q <= 2'h0;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// [rtl/manchester_sinc_adc_frontend.v]
/*
 * Converter front end: three Manchester decoders, six cubic sinc filters,
 * sample, control, status and modulator clock measurement registers on APB.
 * Assumes modLine and refClk32k are asynchronous pins, and a 100 MHz ref_clk
 * well above the modulator bit rate.
 */
// Our own choices: the APB interface to the registers and the placing of the registers.
// Notes on behaviour
// R1: each decoder pulls clock and data out of the composite coded line.
// R2: sync detector hunts for the pattern, then stays aligned to frames.
// R3: channel bits are used only while that decoder reports lock.
// R4: three decoders feed six cubic sinc filters, two per decoder.
// R5: each filter gives 24 bits; significant bits depend on oversampling.
// R6: upper 16 result bits readable in each filter's high-word register.
// R7: lower 8 result bits readable in each filter's low-byte register.
// R8: filters 0,1 from decoder 0; 2,3 from 1; 4,5 from 2.
// R9: control register holds ratio, decoder enables, interrupt enables, status.
// R10: ratio field selects 32, 64, 128 or 256.
// R11: clock count is sync bits of chosen decoder in 512 reference periods.
// R12: decoders run at the external modulator's rate, not a local one.
// R13: status register shows each decoder's lock individually.
// R14: status register select bits choose which decoder is measured.
// R15: lock bit rises once pattern is found after enabling a decoder.
// R16: pair ready flag rises when new samples land in the pair's registers.
// R17: software sets ratio, enables decoder, polls ready before reading samples.
// R18: every register is reachable from either core over the shared bus.
// R19: after reset decoders off, flags clear, sample registers zero.
// R20: reading a pair's first high word clears ready; next output sets it.
`timescale 1ns/1ps
`default_nettype none
`include "adc_frontend_regs.vh"

module manchester_sinc_adc_frontend (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire [11:0] paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [2:0]  modLine,
    input  wire        refClk32k
);

    // last decimation count for each ratio code [R10]
    function [7:0] osrLast;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    osrLast = 8'h1f;
                2'h1:    osrLast = 8'h3f;
                2'h2:    osrLast = 8'h7f;
                default: osrLast = 8'hff;
            endcase
        end
    endfunction

    // left-justify so full scale always fills 24 bits, saturating at the top [R5]
    function [23:0] scaleSample;
        input [25:0] raw;
        input [1:0]  sel;
        reg   [34:0] wide;
        begin
            wide = {9'h000, raw};
            case (sel)
                2'h0:    wide = wide << 9;
                2'h1:    wide = wide << 6;
                2'h2:    wide = wide << 3;
                default: wide = wide;
            endcase
            if (wide[34:24] != 11'h000)
                scaleSample = 24'hffffff;
            else
                scaleSample = wide[23:0];
        end
    endfunction

    reg [1:0]   osrSel_q;
    reg [2:0]   decEnable_q;
    reg [2:0]   irqEnable_q;
    reg [2:0]   pairReady_q;
    reg [1:0]   measSel_q;
    reg [15:0]  clockCount_q;
    reg [15:0]  syncCount_q;
    reg [8:0]   windowCnt_q;
    reg         refSync1_q;
    reg         refSync2_q;
    reg         refPrev_q;
    reg [31:0]  readMux;
    reg         addrHit;
    reg [2:0]   clearReady;

    wire [2:0]  locked;
    wire [2:0]  frameStrobe;
    wire [2:0]  syncStrobe;
    wire [2:0]  ch0Bit;
    wire [2:0]  ch1Bit;
    wire [2:0]  frameTick;
    wire [2:0]  decimEnd;
    wire [2:0]  publish;
    wire [2:0]  filterClear;
    wire [143:0] samplesFlat;

    wire        accessPhase = psel && penable;
    wire        taken       = accessPhase && pready;
    wire        wrTaken     = taken && pwrite && !pslverr;
    wire        rdTaken     = taken && !pwrite && !pslverr;
    wire        refRise     = refSync2_q && !refPrev_q;

    genvar d;
    genvar g;

    // one decoder per line, each running off its own modulator's edges [R4] [R12]
    generate
        for (d = 0; d < 3; d = d + 1) begin : dec
            reg [7:0] decim_q;
            reg [1:0] settle_q;

            manchester_decoder u_decoder (
                .clk         (ref_clk),
                .rst         (rst),
                .enable      (decEnable_q[d]),
                .lineIn      (modLine[d]),
                .locked      (locked[d]),
                .frameStrobe (frameStrobe[d]),
                .syncStrobe  (syncStrobe[d]),
                .ch0Bit      (ch0Bit[d]),
                .ch1Bit      (ch1Bit[d])
            );

            // filters advance only on locked frames of an enabled decoder [R3]
            assign frameTick[d]   = frameStrobe[d] && locked[d] && decEnable_q[d];
            assign filterClear[d] = !locked[d] || !decEnable_q[d];
            assign decimEnd[d]    = frameTick[d] && (decim_q >= osrLast(osrSel_q));
            // first three outputs after lock are filter fill, not samples
            assign publish[d]     = decimEnd[d] && (settle_q == 2'h3);

            always @(posedge ref_clk) begin
                if (rst || filterClear[d]) begin
                    decim_q  <= 8'h00;
                    settle_q <= 2'h0;
                end else if (frameTick[d]) begin
                    if (decimEnd[d]) begin
                        decim_q <= 8'h00;
                        if (settle_q != 2'h3)
                            settle_q <= settle_q + 2'h1;
                    end else begin
                        decim_q <= decim_q + 8'h01;
                    end
                end
            end
        end
    endgenerate

    // six cubic sinc filters, channel pair 2k/2k+1 fed by decoder k [R4] [R8]
    generate
        for (g = 0; g < 6; g = g + 1) begin : chan
            localparam integer D = g / 2;
            reg  [25:0] int1_q;
            reg  [25:0] int2_q;
            reg  [25:0] int3_q;
            reg  [25:0] comb1_q;
            reg  [25:0] comb2_q;
            reg  [25:0] comb3_q;
            reg  [23:0] sample_q;
            wire        bitIn = (g % 2 == 0) ? ch0Bit[D] : ch1Bit[D];
            wire [25:0] diff1 = int3_q - comb1_q;
            wire [25:0] diff2 = diff1 - comb2_q;
            wire [25:0] diff3 = diff2 - comb3_q;

            // wrap-around arithmetic is safe: gain 2^24 fits the 26-bit path
            always @(posedge ref_clk) begin
                if (rst || filterClear[D]) begin
                    int1_q  <= 26'h0000000;
                    int2_q  <= 26'h0000000;
                    int3_q  <= 26'h0000000;
                    comb1_q <= 26'h0000000;
                    comb2_q <= 26'h0000000;
                    comb3_q <= 26'h0000000;
                end else if (frameTick[D]) begin
                    int1_q <= int1_q + {25'h0000000, bitIn};
                    int2_q <= int2_q + int1_q;
                    int3_q <= int3_q + int2_q;
                    if (decimEnd[D]) begin
                        comb1_q <= int3_q;
                        comb2_q <= diff1;
                        comb3_q <= diff2;
                    end
                end
            end

            // samples survive loss of lock; only reset zeroes them [R5] [R19]
            always @(posedge ref_clk) begin
                if (rst)
                    sample_q <= `SAMPLE_RESET;
                else if (publish[D])
                    sample_q <= scaleSample(diff3, osrSel_q);
            end

            assign samplesFlat[g*24 +: 24] = sample_q;
        end
    endgenerate

    // ready flags: a new output wins over a clearing read in the same cycle [R16] [R20]
    always @(posedge ref_clk) begin : readyFlags
        integer p;
        if (rst) begin
            pairReady_q <= 3'h0;
        end else begin
            for (p = 0; p < 3; p = p + 1)
                pairReady_q[p] <= publish[p] || (pairReady_q[p] && !clearReady[p]);
        end
    end

    // reference clock pin: synchronise, then rising-edge detect on the second stage
    always @(posedge ref_clk) begin
        if (rst) begin
            refSync1_q <= 1'b0;
            refSync2_q <= 1'b0;
            refPrev_q  <= 1'b0;
        end else begin
            refSync1_q <= refClk32k;
            refSync2_q <= refSync1_q;
            refPrev_q  <= refSync2_q;
        end
    end

    // sync bits of the selected decoder per 512 reference periods [R11] [R14]
    wire        measSync  = (measSel_q != 2'h3) && syncStrobe[measSel_q];
    wire [15:0] syncInc   = (syncCount_q != 16'hffff && measSync) ? 16'h0001 : 16'h0000;
    wire [15:0] syncTotal = syncCount_q + syncInc;

    always @(posedge ref_clk) begin
        if (rst) begin
            windowCnt_q  <= 9'h000;
            syncCount_q  <= 16'h0000;
            clockCount_q <= 16'h0000;
        end else if (refRise) begin
            windowCnt_q <= windowCnt_q + 9'h001;
            if (windowCnt_q == `MEAS_WINDOW_LAST) begin
                clockCount_q <= syncTotal;
                syncCount_q  <= 16'h0000;
            end else begin
                syncCount_q <= syncTotal;
            end
        end else begin
            syncCount_q <= syncTotal;
        end
    end

    // address decode and read data; one bus serves both cores alike [R18]
    always @* begin : decode
        integer k;
        readMux    = 32'h00000000;
        addrHit    = 1'b0;
        clearReady = 3'h0;
        if (paddr == `CTRL_OFFSET) begin
            addrHit = 1'b1;
            // ratio, enables, interrupt enables and ready status in one word [R9]
            readMux[`CTRL_OSR_MSB:`CTRL_OSR_LSB]       = osrSel_q;
            readMux[`CTRL_ENABLE_MSB:`CTRL_ENABLE_LSB] = decEnable_q;
            readMux[`CTRL_IRQEN_MSB:`CTRL_IRQEN_LSB]   = irqEnable_q;
            readMux[`CTRL_READY_MSB:`CTRL_READY_LSB]   = pairReady_q;
        end
        if (paddr == `SYNC_STATUS_OFFSET) begin
            addrHit = 1'b1;
            readMux[`STAT_LOCK_MSB:`STAT_LOCK_LSB] = locked;      // [R13] [R15]
            readMux[`STAT_MSEL_MSB:`STAT_MSEL_LSB] = measSel_q;   // [R14]
        end
        if (paddr == `CLOCK_COUNT_OFFSET) begin
            addrHit       = 1'b1;
            readMux[15:0] = clockCount_q;                         // [R11]
        end
        for (k = 0; k < 6; k = k + 1) begin
            if (paddr == `HIGH_WORD_BASE + k * 4) begin
                addrHit       = 1'b1;
                readMux[15:0] = samplesFlat[k*24+8 +: 16];        // [R6]
                if (k % 2 == 0)
                    clearReady[k/2] = rdTaken;                    // [R20]
            end
            if (paddr == `LOW_BYTE_BASE + k * 4) begin
                addrHit      = 1'b1;
                readMux[7:0] = samplesFlat[k*24 +: 8];            // [R7]
            end
        end
    end

    // one wait state: data and error are registered, then taken at the pready edge
    always @(posedge ref_clk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (accessPhase && !pready) begin
            pready  <= 1'b1;
            pslverr <= !addrHit;
            prdata  <= pwrite ? 32'h00000000 : readMux;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // writable fields sit in byte lane 0; reset leaves every decoder off [R9] [R19]
    always @(posedge ref_clk) begin
        if (rst) begin
            osrSel_q    <= `CTRL_OSR_RESET;
            decEnable_q <= `CTRL_ENABLE_RESET;
            irqEnable_q <= `CTRL_IRQEN_RESET;
            measSel_q   <= `MSEL_RESET;
        end else if (wrTaken && pstrb[0]) begin
            if (paddr == `CTRL_OFFSET) begin
                osrSel_q    <= pwdata[`CTRL_OSR_MSB:`CTRL_OSR_LSB];       // [R10]
                decEnable_q <= pwdata[`CTRL_ENABLE_MSB:`CTRL_ENABLE_LSB];
                irqEnable_q <= pwdata[`CTRL_IRQEN_MSB:`CTRL_IRQEN_LSB];
            end
            if (paddr == `SYNC_STATUS_OFFSET)
                measSel_q <= pwdata[`STAT_MSEL_MSB:`STAT_MSEL_LSB];      // [R14]
        end
    end

endmodule
`default_nettype wire

// [sim/adc_frontend_asserts.sv]
/* Port-level checks of the converter front end.
   Assumes an APB master that holds each request until pready. */
`timescale 1ns/1ps
`default_nettype none
`include "adc_frontend_regs.vh"
module adc_frontend_asserts (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [2:0]  modLine,
    input wire logic        refClk32k
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic rdDone;
    logic mapped;
    assign rdDone = pready && !pwrite && !pslverr;
    assign mapped = paddr[1:0] == 2'h0 && (paddr <= `CLOCK_COUNT_OFFSET
                    || (paddr >= `HIGH_WORD_BASE && paddr <= 12'h024)
                    || (paddr >= `LOW_BYTE_BASE && paddr <= 12'h044));
    one_wait_state_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not one cycle after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    unmapped_error_a: assert property (pready && !mapped |-> pslverr)
        else $error("unmapped access without error");
    mapped_clean_a: assert property (pready && mapped |-> !pslverr)
        else $error("error on mapped access");
    reset_quiet_a: assert property ($fell(rst) |-> !pready && !pslverr && prdata == 32'h0)
        else $error("bus outputs not quiet after reset");
    ctrl_fields_a: assert property (rdDone && paddr == `CTRL_OFFSET |-> prdata[31:11] == 21'h0)
        else $error("control reserved bits set");
    status_fields_a: assert property (rdDone && paddr == `SYNC_STATUS_OFFSET
        |-> prdata[31:6] == 26'h0 && !prdata[3])
        else $error("status reserved bits set");
    high_word_a: assert property (rdDone && paddr >= `HIGH_WORD_BASE && paddr < `LOW_BYTE_BASE
        |-> prdata[31:16] == 16'h0)
        else $error("high word wider than 16 bits");
    low_byte_a: assert property (rdDone && paddr >= `LOW_BYTE_BASE |-> prdata[31:8] == 24'h0)
        else $error("low byte wider than 8 bits");
endmodule
bind manchester_sinc_adc_frontend adc_frontend_asserts u_chk (
    .ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .modLine(modLine), .refClk32k(refClk32k));
`default_nettype wire

// [sim/modulator_model.sv]
/* Behavioural dual-channel modulator with Manchester composite output.
   Assumes nothing of the receiver; runs on its own free clock. */
`timescale 1ns/1ps
`default_nettype none
`include "adc_frontend_regs.vh"
module modulator_model #(
    parameter logic CH0 = 1'b1,
    parameter logic CH1 = 1'b0
) (
    input  wire logic badSync,
    output logic      line
);
    logic       modClk = 1'b0;
    logic [7:0] pattern = `SYNC_PATTERN;
    logic       bitVal;
    int         slot = 0;
    int         idx = 0;
    // free running and unrelated in phase and rate to ref_clk
    initial forever #4.85 modClk = ~modClk;
    initial begin
        line = 1'b0;
        forever begin
            // zeroed sync bits never match any rotation of the pattern
            bitVal = slot == 0 ? pattern[7 - idx] & ~badSync : (slot == 1 ? CH0 : CH1);
            line <= ~bitVal;
            repeat (10) @(posedge modClk);
            line <= bitVal;
            repeat (10) @(posedge modClk);
            if (slot == 2) idx = (idx + 1) % 8;
            slot = (slot + 1) % 3;
        end
    end
endmodule
`default_nettype wire

// [sim/testbench.sv]
/* Self-checking bench: APB register tests against three modulator models.
   Assumes a one-wait-state APB slave; the 32 kHz reference is sped up. */
`timescale 1ns/1ps
`default_nettype none
`include "adc_frontend_regs.vh"
module testbench;
    localparam logic [5:0] FULL = 6'b111001;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] paddr = 12'h0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hf;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    wire  [2:0]  modLine;
    logic        refClk32k = 1'b0;
    logic        badSync = 1'b0;
    logic        otherBadSync = 1'b0;
    logic [31:0] rd;
    logic        err;
    int          error_cnt = 0;
    int          compares = 0;
    int          cycles = 0;
    int          k;

    manchester_sinc_adc_frontend u_dut (.ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .modLine(modLine), .refClk32k(refClk32k));
    modulator_model u_mod0 (.badSync(badSync), .line(modLine[0]));
    modulator_model #(.CH0(1'b0), .CH1(1'b1)) u_mod1 (.badSync(otherBadSync), .line(modLine[1]));
    modulator_model #(.CH0(1'b1), .CH1(1'b1)) u_mod2 (.badSync(otherBadSync), .line(modLine[2]));

    initial forever #5 ref_clk = ~ref_clk;
    // 400 ns stand-in keeps a 512-period window near 20k cycles
    initial forever #200 refClk32k = ~refClk32k;

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic checkRange(input string what, input int lo, input int hi, input logic [31:0] got);
        compares++;
        if ($isunknown(got) || got < lo || got > hi) begin
            error_cnt++;
            $display("BAD %s expected %0d..%0d seen %h", what, lo, hi, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) error_cnt++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, exp, rd);
    endtask

    task automatic poll(input string what, input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while ((rd & m) !== exp && n < 5000);
        check(what, exp, rd & m);
    endtask

    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rdchk("control", `CTRL_OFFSET, 32'h0);
        rdchk("status", `SYNC_STATUS_OFFSET, 32'h0);
        rdchk("clock count", `CLOCK_COUNT_OFFSET, 32'h0);
        for (k = 0; k < 6; k++) begin
            rdchk("high word", 12'(`HIGH_WORD_BASE + 4 * k), 32'h0);
            rdchk("low byte", 12'(`LOW_BYTE_BASE + 4 * k), 32'h0);
        end
        apb(1'b0, 12'h100, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        apb(1'b1, 12'h001, 32'h1f);
        check("unaligned error", 32'h1, {31'h0, err});
        rdchk("control untouched", `CTRL_OFFSET, 32'h0);
        for (k = 0; k < 4; k++) begin
            apb(1'b1, `CTRL_OFFSET, 32'he0 | k);
            rdchk("ratio code", `CTRL_OFFSET, 32'he0 | k);
        end
        pstrb <= 4'he;
        apb(1'b1, `CTRL_OFFSET, 32'h0);
        pstrb <= 4'hf;
        rdchk("strobe off write", `CTRL_OFFSET, 32'he3);
        apb(1'b1, `CLOCK_COUNT_OFFSET, 32'hffff);
        rdchk("count read only", `CLOCK_COUNT_OFFSET, 32'h0);
        apb(1'b1, `SYNC_STATUS_OFFSET, 32'h37);
        rdchk("measure select", `SYNC_STATUS_OFFSET, 32'h30);
        apb(1'b1, `SYNC_STATUS_OFFSET, 32'h0);
        apb(1'b1, `CTRL_OFFSET, 32'h1c);
        poll("all locked", `SYNC_STATUS_OFFSET, 32'h7, 32'h7);
        poll("all ready", `CTRL_OFFSET, 32'h700, 32'h700);
        for (k = 0; k < 6; k++) begin
            rdchk("low byte", 12'(`LOW_BYTE_BASE + 4 * k), FULL[k] ? 32'hff : 32'h0);
            rdchk("high word", 12'(`HIGH_WORD_BASE + 4 * k), FULL[k] ? 32'hffff : 32'h0);
        end
        rdchk("ready cleared", `CTRL_OFFSET, 32'h1c);
        poll("ready again", `CTRL_OFFSET, 32'h700, 32'h700);
        // 512 reference periods span about 20k cycles; two make a full window certain
        repeat (42000) @(posedge ref_clk);
        apb(1'b0, `CLOCK_COUNT_OFFSET, 32'h0);
        checkRange("clock count", 350, 353, rd);
        badSync <= 1'b1;
        poll("lock lost", `SYNC_STATUS_OFFSET, 32'h7, 32'h6);
        rdchk("sample kept", `HIGH_WORD_BASE, 32'hffff);
        badSync <= 1'b0;
        poll("relocked", `SYNC_STATUS_OFFSET, 32'h7, 32'h7);
        apb(1'b1, `CTRL_OFFSET, 32'h18);
        poll("disabled unlock", `SYNC_STATUS_OFFSET, 32'h7, 32'h6);
        otherBadSync <= 1'b1;
        poll("others unlock", `SYNC_STATUS_OFFSET, 32'h7, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
